// *** bench/ddrp_ctl_model.sv ***
`timescale 1ns/10ps
// ==========================================================
// memory controller model: link clock, commands, write beats
module ddrp_ctl_model (
  input  wire logic        core_clk, // bench timing
  output logic             clk_true, // link clock true
  output logic             clk_comp, // link clock comp
  output logic             cke,      // clock enable
  output logic             cs_n,     // chip select, low
  output logic [9:0]       ca,       // cmd/addr pins
  output logic [31:0]      dq,       // write data
  output logic [3:0]       dqs_t,    // write strobe true
  output logic [3:0]       dm        // write masks
);
  // link clock stands still between frames
  initial begin
    clk_true = 1'b0;
    clk_comp = 1'b1;
    cke = 1'b1;
    cs_n = 1'b1;
    ca = 10'h3ff;
    dq = 32'h0000_0000;
    dqs_t = 4'h0;
    dm = 4'h0;
  end
  // one link cycle, half per edge
  task automatic link_cyc(input logic [9:0] r, input logic [9:0] f,
                          input logic csr, input logic csf);
    @(negedge core_clk);
    cs_n = csr;
    ca = r;
    @(negedge core_clk);
    {clk_true, clk_comp} = 2'b10;
    repeat (3) @(negedge core_clk);
    cs_n = csf;
    ca = f;
    @(negedge core_clk);
    {clk_true, clk_comp} = 2'b01;
    repeat (3) @(negedge core_clk);
    cs_n = 1'b1;
    ca = ~f;
  endtask : link_cyc
  task automatic set_cke(input logic v);
    @(negedge core_clk);
    cke = v;
  endtask : set_cke
  // data set before the strobe edge
  task automatic wbeat(input logic [31:0] d, input logic [3:0] m);
    @(negedge core_clk);
    dq = d;
    dm = m;
    @(negedge core_clk);
    dqs_t = ~dqs_t;
  endtask : wbeat
  // released lines show the inverse of the last beat
  task automatic wrel();
    repeat (3) @(negedge core_clk);
    dq = ~dq;
    dm = ~dm;
  endtask : wrel
endmodule : ddrp_ctl_model

// *** bench/ddrp_props.sv ***
`timescale 1ns/10ps
// ==========================================================
// port checker for the pin and address rules
module ddrp_props (
  input wire logic        core_clk,     // core clock
  input wire logic        sys_rst,      // async reset
  input wire logic        cfg_x32,      // width select
  input wire logic        scan_enable_in, // scan pin
  input wire logic        rd_drive,     // read window
  input wire logic        rd_beat,      // read beat
  input wire logic [31:0] rd_data,      // read data
  input wire logic [31:0] dq_out,       // data out
  input wire logic [31:0] dq_oe,        // data drive
  input wire logic [3:0]  dqs_t_out,    // strobe out
  input wire logic [3:0]  dqs_oe,       // strobe drive
  input wire logic        cmd_valid,    // head valid
  input wire logic        cmd_ready,    // head taken
  input wire logic [9:0]  cmd_rise,     // rising half
  input wire logic [9:0]  cmd_fall,     // falling half
  input wire logic [2:0]  bank_sel,     // bank
  input wire logic [13:0] row_addr,     // row
  input wire logic [9:0]  col_addr,     // column
  input wire logic        cmd_overflow, // sticky loss
  input wire logic        wr_valid,     // beat pulse
  input wire logic [3:0]  wr_byte_en,   // kept bytes
  input wire logic        clk_active,   // cke level
  input wire logic        scan_active   // scan mode
);
  // active lanes follow the width strap
  wire logic [3:0] lane_on = cfg_x32 ? 4'hf : 4'h3;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  col_lsb_a: assert property (col_addr[0] == 1'b0)
    else $error("column bit zero not clear");
  col_x32_a: assert property (cfg_x32 |-> !col_addr[9])
    else $error("x32 column top bit set");
  col_map_a: assert property ((cmd_valid && !cfg_x32) |->
    col_addr[9:1] == cmd_fall[9:1]) else $error("column map wrong");
  row_map_a: assert property (cmd_valid |->
    row_addr == {cmd_rise[6:2], cmd_fall[8:0]}) else $error("row map");
  bank_map_a: assert property (cmd_valid |->
    bank_sel == cmd_rise[9:7]) else $error("bank map wrong");
  head_hold_a: assert property ((cmd_valid && !cmd_ready) |=>
    cmd_valid && $stable(cmd_rise) && $stable(cmd_fall))
    else $error("command head moved");
  x16_quiet_a: assert property ((!cfg_x32 && !$past(cfg_x32)) |->
    dq_oe[31:16] == 16'h0000 && dqs_oe[3:2] == 2'h0 &&
    dq_out[31:16] == 16'h0000) else $error("x16 upper lanes active");
  byte_lane_a: assert property (wr_valid |->
    (wr_byte_en & ~lane_on) == 4'h0) else $error("dead lane kept");
  beat_pulse_a: assert property (wr_valid |=> !wr_valid)
    else $error("write beat longer than one cycle");
  cke_off_a: assert property ((!clk_active && !$past(clk_active))
    |-> dq_oe == 32'h0000_0000 && dqs_oe == 4'h0 && !wr_valid)
    else $error("activity while clock enable low");
  read_beat_a: assert property ((rd_drive && rd_beat && clk_active)
    |=> dq_oe[0] && dq_out[7:0] == $past(rd_data[7:0]) &&
    dqs_t_out[0] != $past(dqs_t_out[0])) else $error("read beat");
  scan_on_a: assert property ($rose(scan_enable_in)
    |-> ##[1:4] scan_active) else $error("scan mode not seen");
  cover property (cmd_valid && cmd_ready);
  cover property (wr_valid && wr_byte_en != lane_on);
  cover property ($rose(cmd_overflow));
endmodule : ddrp_props

bind ddrp_top ddrp_props u_props (
  .core_clk(core_clk), .sys_rst(sys_rst), .cfg_x32(cfg_x32),
  .scan_enable_in(scan_enable_in), .rd_drive(rd_drive),
  .rd_beat(rd_beat), .rd_data(rd_data), .dq_out(dq_out),
  .dq_oe(dq_oe), .dqs_t_out(dqs_t_out), .dqs_oe(dqs_oe),
  .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_rise(cmd_rise),
  .cmd_fall(cmd_fall), .bank_sel(bank_sel), .row_addr(row_addr),
  .col_addr(col_addr), .cmd_overflow(cmd_overflow),
  .wr_valid(wr_valid), .wr_byte_en(wr_byte_en),
  .clk_active(clk_active), .scan_active(scan_active));

// *** bench/tb_ddr_sdram_pin_addressing.sv ***
`timescale 1ns/10ps
// ==========================================================
// bench for the device pin front end
module tb_ddr_sdram_pin_addressing;
  logic        core_clk, sys_rst, cfg_x32, scan_enable_in;
  logic        cmd_ready, overflow_clr, rd_drive, rd_beat;
  logic [31:0] rd_data, m_dq, dq_in, dq_out, dq_oe, wr_data;
  logic [3:0]  m_dqs, m_dm, dqs_t_in, dqs_c_in, dqs_t_out, dqs_c_out;
  logic [3:0]  dqs_oe, wr_byte_en;
  logic        clk_true, clk_comp, cke_in, cs_n_in, cmd_valid;
  logic        cmd_overflow, wr_valid, clk_active, scan_active;
  logic [9:0]  cmd_addr_bus, cmd_rise, cmd_fall, col_addr;
  logic [2:0]  bank_sel;
  logic [13:0] row_addr;
  int          n_fail, check_count, cyc, n_wr;
  wire logic [3:0]  lane = cfg_x32 ? 4'hf : 4'h3;
  wire logic [31:0] dmask = cfg_x32 ? 32'hffff_ffff : 32'h0000_ffff;
  // pin level from the dut where its enable is set, else from the model
  assign dq_in = (dq_oe & dq_out) | (~dq_oe & m_dq);
  assign dqs_t_in = (dqs_oe & dqs_t_out) | (~dqs_oe & m_dqs);
  assign dqs_c_in = (dqs_oe & dqs_c_out) | (~dqs_oe & ~m_dqs);
  ddrp_ctl_model ctl (.core_clk(core_clk), .clk_true(clk_true),
    .clk_comp(clk_comp), .cke(cke_in), .cs_n(cs_n_in),
    .ca(cmd_addr_bus), .dq(m_dq), .dqs_t(m_dqs), .dm(m_dm));
  ddrp_top dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .cfg_x32(cfg_x32), .clk_true(clk_true), .clk_comp(clk_comp),
    .cke_in(cke_in), .cs_n_in(cs_n_in), .cmd_addr_bus(cmd_addr_bus),
    .scan_enable_in(scan_enable_in), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .dqs_t_in(dqs_t_in), .dqs_c_in(dqs_c_in),
    .dqs_t_out(dqs_t_out), .dqs_c_out(dqs_c_out), .dqs_oe(dqs_oe),
    .write_mask(m_dm), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_rise(cmd_rise), .cmd_fall(cmd_fall), .bank_sel(bank_sel),
    .row_addr(row_addr), .col_addr(col_addr),
    .cmd_overflow(cmd_overflow), .overflow_clr(overflow_clr),
    .wr_valid(wr_valid), .wr_data(wr_data), .wr_byte_en(wr_byte_en),
    .rd_drive(rd_drive), .rd_beat(rd_beat), .rd_data(rd_data),
    .clk_active(clk_active), .scan_active(scan_active));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  // hang guard, far above the few hundred cycles needed
  always @(posedge core_clk) begin
    cyc++;
    if (wr_valid === 1'b1) n_wr++;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic final_report();
    if (n_fail == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  task automatic wait_cmd();
    for (int i = 0; i < 20 && cmd_valid !== 1'b1; i++)
      @(negedge core_clk);
  endtask : wait_cmd
  task automatic pop();
    @(negedge core_clk);
    cmd_ready = 1'b1;
    @(negedge core_clk);
    cmd_ready = 1'b0;
  endtask : pop
  // one command, all decoded fields, chip select high at fall edge
  task automatic cmd_case(input logic [9:0] r, input logic [9:0] f);
    ctl.link_cyc(r, f, 1'b0, 1'b1);
    wait_cmd();
    chk("cmd_valid", cmd_valid, 1);
    chk("cmd_rise", cmd_rise, r);
    chk("cmd_fall", cmd_fall, f);
    chk("bank_sel", bank_sel, r[9:7]);
    chk("row_addr", row_addr, {r[6:2], f[8:0]});
    chk("col_addr", col_addr, {!cfg_x32 & f[9], f[8:1], 1'b0});
    pop();
  endtask : cmd_case
  // write beat with masks, lanes judged against the width
  task automatic wr_case(input logic [31:0] d, input logic [3:0] m);
    ctl.wbeat(d, m);
    for (int i = 0; i < 6 && wr_valid !== 1'b1; i++)
      @(negedge core_clk);
    chk("wr_valid", wr_valid, 1);
    chk("wr_byte_en", wr_byte_en, ~m & lane);
    chk("wr_data", wr_data & dmask, d & dmask);
    ctl.wrel();
  endtask : wr_case
  // two back to back read beats then release
  task automatic t_read(input logic [31:0] d);
    @(negedge core_clk);
    {rd_drive, rd_beat, rd_data} = {2'b11, d};
    @(negedge core_clk);
    chk("dq_out", dq_out, d & dmask);
    chk("dqs_t_out", dqs_t_out & lane, lane);
    chk("dqs_oe", dqs_oe, lane);
    rd_data = ~d;
    @(negedge core_clk);
    chk("dq_out", dq_out, ~d & dmask);
    chk("dqs_t_out", dqs_t_out & lane, 0);
    chk("dqs_c_out", dqs_c_out, lane);
    {rd_drive, rd_beat} = 2'b00;
    repeat (2) @(negedge core_clk);
    chk("dq_oe", dq_oe, 0);
  endtask : t_read
  // eight kept, ninth lost and flagged, drained in order
  task automatic t_fifo();
    for (int i = 0; i < 9; i++)
      ctl.link_cyc(10'(i), 10'(i + 8), 1'b0, 1'b0);
    repeat (6) @(negedge core_clk);
    chk("cmd_overflow", cmd_overflow, 1);
    for (int i = 0; i < 8; i++) begin
      wait_cmd();
      chk("cmd_rise", cmd_rise, 10'(i));
      pop();
    end
    chk("cmd_valid", cmd_valid, 0);
    overflow_clr = 1'b1;
    @(negedge core_clk);
    overflow_clr = 1'b0;
    @(negedge core_clk);
    chk("cmd_overflow", cmd_overflow, 0);
  endtask : t_fifo
  // clock enable low: no command, no beat, clk_active low
  task automatic t_cke();
    int nw;
    ctl.link_cyc(10'h155, 10'h0aa, 1'b1, 1'b0);
    ctl.set_cke(1'b0);
    ctl.link_cyc(10'h0f0, 10'h00f, 1'b0, 1'b0);
    repeat (8) @(negedge core_clk);
    chk("cmd_valid", cmd_valid, 0);
    chk("clk_active", clk_active, 0);
    nw = n_wr;
    ctl.wbeat(32'h1234_5678, 4'h0);
    ctl.wrel();
    repeat (3) @(negedge core_clk);
    chk("wr_beats", 32'(n_wr - nw), 0);
    ctl.set_cke(1'b1);
    ctl.link_cyc(10'h3ff, 10'h3ff, 1'b1, 1'b1);
    repeat (6) @(negedge core_clk);
    chk("clk_active", clk_active, 1);
  endtask : t_cke
  task automatic t_scan();
    @(negedge core_clk);
    scan_enable_in = 1'b1;
    repeat (5) @(negedge core_clk);
    chk("scan_active", scan_active, 1);
    scan_enable_in = 1'b0;
    repeat (5) @(negedge core_clk);
    chk("scan_active", scan_active, 0);
  endtask : t_scan
  initial begin
    {sys_rst, cfg_x32, scan_enable_in, cmd_ready} = 4'b1000;
    {overflow_clr, rd_drive, rd_beat, rd_data} = 35'h0;
    repeat (12) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge core_clk);
    cmd_case(10'h3a5, 10'h2c7);
    wr_case(32'hcafe_1357, 4'b0010);
    wr_case(32'h2468_ace0, 4'b1101);
    t_read(32'h5a3c_96e1);
    cfg_x32 = 1'b1;
    cmd_case(10'h15a, 10'h3ff);
    wr_case(32'h8765_4321, 4'b0100);
    wr_case(32'h0f1e_2d3c, 4'b1011);
    t_read(32'h9abc_def0);
    t_fifo();
    t_cke();
    t_scan();
    final_report();
  end
endmodule : tb_ddr_sdram_pin_addressing

// *** hdl/ddrp_fifo.sv ***
`timescale 1ns/10ps
module ddrp_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic   clk,   // core clock
  input  wire logic   rst,   // async reset, active high
  ddrp_stream_if.snk  wr,    // filling side
  ddrp_stream_if.src  rd     // draining side
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  // =========================================================
  // handshakes: full and empty come straight from the count
  assign wr.ready = (cnt_q != (AW+1)'(DEPTH));
  assign rd.valid = (cnt_q != '0);
  assign rd.data  = mem[rp_q];
  assign push     = wr.valid & wr.ready;
  assign pop      = rd.valid & rd.ready;

  // storage has no reset; only pointers matter
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= wr.data;
    end
  end

  // pointer and occupancy bookkeeping
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= AW'((wp_q + 1'b1) % DEPTH);
      if (pop)  rp_q <= AW'((rp_q + 1'b1) % DEPTH);
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end
endmodule : ddrp_fifo

// *** hdl/ddrp_pkg.sv ***
package ddrp_pkg;

  // =========================================================
  // bus widths
  localparam int CA_W      = 10;
  localparam int DQ_W      = 32;
  localparam int LANES     = 4;
  localparam int LANES_X16 = 2;
  localparam int BYTE_W    = 8;
  localparam int BANK_W    = 3;
  localparam int ROW_W     = 14;
  localparam int COL_W     = 10;
  localparam int CMD_W     = 2 * CA_W;
  localparam int FIFO_DEPTH = 8;

  // =========================================================
  // field positions inside the two command halves
  localparam int BANK_LSB    = 7;  // rising half, 3 bits
  localparam int ROW_HI_LSB  = 2;  // rising half, 5 bits
  localparam int ROW_HI_W    = 5;
  localparam int ROW_LO_W    = 9;  // falling half, bits 8:0
  localparam int COL_LSB     = 1;  // falling half, col[9:1]
  localparam int COL_X32_TOP = 9;  // column bit unused in x32

  // =========================================================
  // reset values
  localparam logic [CA_W-1:0] CA_RST   = 10'h000;
  localparam logic [DQ_W-1:0] DQ_RST   = 32'h0000_0000;
  localparam logic [LANES-1:0] LANE_RST = 4'h0;

  // command capture states
  typedef enum logic [2:0] {
    ST_DOWN = 3'b001,
    ST_IDLE = 3'b010,
    ST_HALF = 3'b100
  } ddrp_state_t;

endpackage : ddrp_pkg

// *** hdl/ddrp_stream_if.sv ***
`timescale 1ns/10ps
interface ddrp_stream_if #(
  parameter int W = 8
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : ddrp_stream_if

// *** hdl/ddrp_sync.sv ***
`timescale 1ns/10ps
module ddrp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,   // core clock
  input  wire logic         rst,   // async reset, active high
  input  wire logic [W-1:0] d,     // asynchronous level
  output logic      [W-1:0] q      // synchronised level
);
  logic [W-1:0] meta_q;

  // =========================================================
  // two stages; the first is read by the second only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : ddrp_sync

// *** hdl/ddrp_top.sv ***
`timescale 1ns/10ps
// Functional notes
// - command/address bus is captured on both link clock edges
// - chip select and clock enable are taken on rising edges only
// - rising edge: true rises, complement low; falling: true falls, comp high
// - clock enable low stops capture, input paths and output drivers
// - a command is chip select, clock enable and both bus halves together
// - read data edge aligned with device strobe; writes use host strobe
// - each strobe pair times one byte lane, lanes 2-3 only in x32
// - a write byte whose mask is high with its beat is discarded
// - write masks are sampled on both edges of the true strobe
// - mask bit n covers byte lane n; masks 2-3 only in x32
// - in x16 upper data, masks 2-3 and strobes 2-3 are ignored
// - boundary scan is active only while scan enable is high
// - row address is 14 bits in both widths
// - x16 uses column bits 0 to 9
// - x32 uses column bits 0 to 8
// - lowest column bit is never carried and always reads zero
// - unused address positions on the bus are ignored
// - one command occupies one link clock cycle, both edges
// - eight banks selected by a 3-bit bank address
module ddrp_top (
  input  wire logic                         core_clk,       // core clock
  input  wire logic                         sys_rst,        // async reset
  input  wire logic                         cfg_x32,        // 1 = x32 mode
  // link clock and command pins
  input  wire logic                         clk_true,       // clock, true
  input  wire logic                         clk_comp,       // clock, comp
  input  wire logic                         cke_in,         // clock enable
  input  wire logic                         cs_n_in,        // chip select
  input  wire logic [ddrp_pkg::CA_W-1:0]    cmd_addr_bus,   // ddr cmd/addr
  input  wire logic                         scan_enable_in, // scan enable
  // data pins, split into in/out/enable
  input  wire logic [ddrp_pkg::DQ_W-1:0]    dq_in,          // data in
  output logic      [ddrp_pkg::DQ_W-1:0]    dq_out,         // data out
  output logic      [ddrp_pkg::DQ_W-1:0]    dq_oe,          // data drive
  input  wire logic [ddrp_pkg::LANES-1:0]   dqs_t_in,       // strobe true
  input  wire logic [ddrp_pkg::LANES-1:0]   dqs_c_in,       // strobe comp
  output logic      [ddrp_pkg::LANES-1:0]   dqs_t_out,      // strobe true
  output logic      [ddrp_pkg::LANES-1:0]   dqs_c_out,      // strobe comp
  output logic      [ddrp_pkg::LANES-1:0]   dqs_oe,         // strobe drive
  input  wire logic [ddrp_pkg::LANES-1:0]   write_mask,     // byte masks
  // decoded command stream toward the core
  output logic                              cmd_valid,      // command ready
  input  wire logic                         cmd_ready,      // core takes it
  output logic      [ddrp_pkg::CA_W-1:0]    cmd_rise,       // rising half
  output logic      [ddrp_pkg::CA_W-1:0]    cmd_fall,       // falling half
  output logic      [ddrp_pkg::BANK_W-1:0]  bank_sel,       // bank address
  output logic      [ddrp_pkg::ROW_W-1:0]   row_addr,       // row address
  output logic      [ddrp_pkg::COL_W-1:0]   col_addr,       // column addr
  output logic                              cmd_overflow,   // sticky loss
  input  wire logic                         overflow_clr,   // clear pulse
  // write beats toward the core
  output logic                              wr_valid,       // beat pulse
  output logic      [ddrp_pkg::DQ_W-1:0]    wr_data,        // beat data
  output logic      [ddrp_pkg::LANES-1:0]   wr_byte_en,     // kept bytes
  // read beats from the core
  input  wire logic                         rd_drive,       // read window
  input  wire logic                         rd_beat,        // beat strobe
  input  wire logic [ddrp_pkg::DQ_W-1:0]    rd_data,        // beat data
  // status
  output logic                              clk_active,     // cke level
  output logic                              scan_active     // scan mode
);

  // =========================================================
  // synchronise every pin before any logic reads it
  localparam int SYN_W = 2 + 2 + ddrp_pkg::CA_W + 1 + ddrp_pkg::DQ_W
                         + 3 * ddrp_pkg::LANES;

  logic [ddrp_pkg::CA_W-1:0]  ca_s;
  logic [ddrp_pkg::DQ_W-1:0]  dq_s;
  logic [ddrp_pkg::LANES-1:0] dqs_t_s;
  logic [ddrp_pkg::LANES-1:0] dqs_c_s;
  logic [ddrp_pkg::LANES-1:0] mask_s;
  logic                       ckt_s;
  logic                       ckc_s;
  logic                       cke_s;
  logic                       cs_n_s;
  logic                       scan_s;

  ddrp_sync #(.W(SYN_W)) u_sync (
    .clk (core_clk),
    .rst (sys_rst),
    .d   ({clk_true, clk_comp, cke_in, cs_n_in, cmd_addr_bus,
           scan_enable_in, dq_in, dqs_t_in, dqs_c_in, write_mask}),
    .q   ({ckt_s, ckc_s, cke_s, cs_n_s, ca_s,
           scan_s, dq_s, dqs_t_s, dqs_c_s, mask_s})
  );

  // =========================================================
  // link clock edge finding
  logic ckt_p_q;
  logic link_rise;
  logic link_fall;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) ckt_p_q <= 1'b0;
    else         ckt_p_q <= ckt_s;
  end

  assign link_rise = ckt_s & ~ckt_p_q & ~ckc_s;
  assign link_fall = ~ckt_s & ckt_p_q & ckc_s;

  // =========================================================
  // command capture state machine
  ddrp_pkg::ddrp_state_t     st_q;
  ddrp_pkg::ddrp_state_t     st_d;
  logic                      cke_q;
  logic [ddrp_pkg::CA_W-1:0] rise_q;
  logic                      push;
  logic                      fifo_ok;
  logic                      sel_hit;

  // sdr inputs: cs and cke only at the rising edge
  assign sel_hit = link_rise & cke_s & ~cs_n_s;
  // one command spans a rising and the following falling edge
  assign push    = (st_q == ddrp_pkg::ST_HALF) & link_fall;

  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ddrp_pkg::ST_DOWN: begin
        // a select at the waking edge is already a command
        if (sel_hit)                st_d = ddrp_pkg::ST_HALF;
        else if (link_rise & cke_s) st_d = ddrp_pkg::ST_IDLE;
      end
      ddrp_pkg::ST_IDLE: begin
        // command needs cs, cke and the bus together
        if (link_rise & ~cke_s) st_d = ddrp_pkg::ST_DOWN;
        else if (sel_hit)       st_d = ddrp_pkg::ST_HALF;
      end
      ddrp_pkg::ST_HALF: begin
        if (link_fall) st_d = ddrp_pkg::ST_IDLE;
      end
      default: st_d = ddrp_pkg::ST_DOWN;
    endcase
  end

  // cke is sampled only on a rising link edge
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q  <= ddrp_pkg::ST_DOWN;
      cke_q <= 1'b0;
    end else begin
      st_q <= st_d;
      if (link_rise) cke_q <= cke_s;
    end
  end

  // rising half held until the falling half arrives
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst)      rise_q <= ddrp_pkg::CA_RST;
    else if (sel_hit) rise_q <= ca_s;
  end

  // a full queue cannot stall the far end: the loss is flagged
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) cmd_overflow <= 1'b0;
    else         cmd_overflow <= (push & ~fifo_ok) |
                                 (cmd_overflow & ~overflow_clr);
  end

  // =========================================================
  // command queue
  ddrp_stream_if #(.W(ddrp_pkg::CMD_W)) q_in  ();
  ddrp_stream_if #(.W(ddrp_pkg::CMD_W)) q_out ();

  // falling half taken live at the falling edge
  assign q_in.valid = push;
  assign q_in.data  = {ca_s, rise_q};
  assign fifo_ok    = q_in.ready;
  assign q_out.ready = cmd_ready;

  ddrp_fifo #(.W(ddrp_pkg::CMD_W), .DEPTH(ddrp_pkg::FIFO_DEPTH)) u_fifo (
    .clk (core_clk),
    .rst (sys_rst),
    .wr  (q_in),
    .rd  (q_out)
  );

  assign cmd_valid = q_out.valid;
  assign cmd_rise  = q_out.data[ddrp_pkg::CA_W-1:0];
  assign cmd_fall  = q_out.data[ddrp_pkg::CMD_W-1:ddrp_pkg::CA_W];

  // =========================================================
  // address fields
  // eight banks
  assign bank_sel = cmd_rise[ddrp_pkg::BANK_LSB +: ddrp_pkg::BANK_W];
  // fourteen row bits in both widths
  assign row_addr = {cmd_rise[ddrp_pkg::ROW_HI_LSB +: ddrp_pkg::ROW_HI_W],
                     cmd_fall[ddrp_pkg::ROW_LO_W-1:0]};

  // column width per mode, bit 0 implied zero
  function automatic logic [ddrp_pkg::COL_W-1:0] col_of(
    input logic [ddrp_pkg::CA_W-1:0] fall,
    input logic                      x32
  );
    logic [ddrp_pkg::COL_W-1:0] c;
    c = {fall[ddrp_pkg::CA_W-1:ddrp_pkg::COL_LSB], 1'b0};
    if (x32) c[ddrp_pkg::COL_X32_TOP] = 1'b0;
    return c;
  endfunction : col_of

  assign col_addr = col_of(cmd_fall, cfg_x32);

  // =========================================================
  // lane helpers
  // only the low two lanes live in x16
  function automatic logic [ddrp_pkg::LANES-1:0] lanes_of(
    input logic x32
  );
    logic [ddrp_pkg::LANES-1:0] l;
    l = x32 ? {ddrp_pkg::LANES{1'b1}}
            : ddrp_pkg::LANES'({ddrp_pkg::LANES_X16{1'b1}});
    return l;
  endfunction : lanes_of

  function automatic logic [ddrp_pkg::DQ_W-1:0] bytes_of(
    input logic [ddrp_pkg::LANES-1:0] l
  );
    logic [ddrp_pkg::DQ_W-1:0] b;
    b = '0;
    for (int i = 0; i < ddrp_pkg::LANES; i++) begin
      b[i*ddrp_pkg::BYTE_W +: ddrp_pkg::BYTE_W] = {ddrp_pkg::BYTE_W{l[i]}};
    end
    return b;
  endfunction : bytes_of

  logic [ddrp_pkg::LANES-1:0] lane_on;
  logic                       io_on;

  assign lane_on = lanes_of(cfg_x32);
  // input buffers and drivers follow the sampled cke
  assign io_on   = cke_q;

  // =========================================================
  // write path: each lane times on its own true strobe
  logic [ddrp_pkg::LANES-1:0] dqs_p_q;
  logic [ddrp_pkg::LANES-1:0] lane_hit;
  logic [ddrp_pkg::DQ_W-1:0]  wr_data_d;
  logic [ddrp_pkg::LANES-1:0] wr_be_d;
  // pin echo lasts the synchroniser depth plus the edge register
  localparam int ECHO_N = 3;
  logic [ECHO_N-1:0]          echo_q;
  logic                       rd_echo;
  logic                       drive_q;

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dqs_p_q <= ddrp_pkg::LANE_RST;
      echo_q  <= '0;
    end else begin
      dqs_p_q <= dqs_t_s;
      echo_q  <= {echo_q[ECHO_N-2:0], drive_q};
    end
  end

  // both edges of the host strobe, lane by lane; our own
  // read strobe comes back late through the synchroniser, so mask it
  assign rd_echo  = drive_q | (|echo_q);
  assign lane_hit = (dqs_t_s ^ dqs_p_q) & (dqs_t_s ^ dqs_c_s) & lane_on
                    & {ddrp_pkg::LANES{io_on & ~rd_echo}};

  always_comb begin
    wr_data_d = wr_data;
    wr_be_d   = wr_byte_en;
    for (int i = 0; i < ddrp_pkg::LANES; i++) begin
      if (lane_hit[i]) begin
        wr_data_d[i*ddrp_pkg::BYTE_W +: ddrp_pkg::BYTE_W] =
          dq_s[i*ddrp_pkg::BYTE_W +: ddrp_pkg::BYTE_W];
        wr_be_d[i] = ~mask_s[i];
      end
    end
  end

  // data and enables held until the next beat
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_data    <= ddrp_pkg::DQ_RST;
      wr_byte_en <= ddrp_pkg::LANE_RST;
      wr_valid   <= 1'b0;
    end else begin
      wr_data    <= wr_data_d;
      wr_byte_en <= wr_be_d;
      wr_valid   <= lane_hit[0];
    end
  end

  // =========================================================
  // read path: data and strobe change together
  logic [ddrp_pkg::LANES-1:0] dqs_t_q;

  // edge aligned: strobe toggles with each new beat
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dq_out  <= ddrp_pkg::DQ_RST;
      dqs_t_q <= ddrp_pkg::LANE_RST;
      drive_q <= 1'b0;
    end else begin
      drive_q <= rd_drive & io_on;
      if (rd_beat & rd_drive & io_on) begin
        dq_out  <= rd_data & bytes_of(lane_on);
        dqs_t_q <= ~dqs_t_q & lane_on;
      end else if (~rd_drive) begin
        dqs_t_q <= ddrp_pkg::LANE_RST;
      end
    end
  end

  // drivers off when cke is low or the lane is unused
  assign dqs_t_out = dqs_t_q;
  assign dqs_c_out = ~dqs_t_q & lane_on;
  assign dqs_oe    = {ddrp_pkg::LANES{drive_q}} & lane_on;
  assign dq_oe     = {ddrp_pkg::DQ_W{drive_q}} & bytes_of(lane_on);

  // =========================================================
  // status
  assign clk_active  = cke_q;
  // scan only while the pin is high
  assign scan_active = scan_s;

endmodule : ddrp_top
